// >>> include/cjh_consts.svh
// Constants for the cutter jog, homing and virtual-master command block.
`ifndef CJH_CONSTS_SVH
`define CJH_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map, word aligned byte addresses
// ----------------------------------------------------------------------
`define CJH_AW 5
`define CJH_OFS_MAP 5'h00
`define CJH_OFS_JOG 5'h04
`define CJH_OFS_TRIM 5'h08
`define CJH_OFS_VMSPD 5'h0C
`define CJH_OFS_RAMP 5'h10
`define CJH_OFS_STAT 5'h14
`define CJH_OFS_VMFRQ 5'h18
`define CJH_OFS_ERR 5'h1C

// ----------------------------------------------------------------------
// Command indices and source selection
// ----------------------------------------------------------------------
`define CJH_NCMD 6
`define CJH_C_JOGF 0
`define CJH_C_JOGR 1
`define CJH_C_HOME 2
`define CJH_C_VSEL 3
`define CJH_C_VRUN 4
`define CJH_C_CLR 5
`define CJH_MAPW 18
`define CJH_NERR 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CJH_MAP_RST 18'h001AC
`define CJH_JOG_RST 16'h0100
`define CJH_TRIM_RST 16'h0040
`define CJH_VMSPD_RST 16'h1000
`define CJH_RAMP_RST 16'h0001

`endif

// >>> include/cjh_pkg.sv
// Types shared by the cutter command block.
package cjh_pkg;
  typedef logic [15:0] cjh_speed_t;
  typedef logic signed [16:0] cjh_vel_t;
  typedef enum logic [1:0] {HOME_IDLE, HOME_SEEK, HOME_MOVE} cjh_home_t;
endpackage : cjh_pkg

// >>> rtl/cjh_vm_ramp.sv
// Virtual-master frequency generator with linear up and down ramps.
`timescale 1ns/1ps
`include "cjh_consts.svh"

module cjh_vm_ramp (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               sysEn,
  input  wire logic               vmRun,
  input  wire cjh_pkg::cjh_speed_t target,
  input  wire cjh_pkg::cjh_speed_t rampStep,
  output      cjh_pkg::cjh_speed_t freq
);
  import cjh_pkg::*;

  // ----------------------------------------------------------------------
  // Ramp arithmetic
  // ----------------------------------------------------------------------
  // A step of zero would freeze the ramp forever, so one is the floor.
  wire cjh_speed_t step = (rampStep == 16'h0000) ? 16'h0001 : rampStep;
  wire cjh_speed_t goal = vmRun ? target : 16'h0000;
  wire             rise = freq < goal;
  wire cjh_speed_t gap  = rise ? goal - freq : freq - goal;
  wire cjh_speed_t next_freq =
    (gap <= step) ? goal : (rise ? freq + step : freq - step);

  // ----------------------------------------------------------------------
  // Frequency register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      freq <= 16'h0000;
    end else if (sysEn) begin
      freq <= next_freq;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_ramp_up;
    sysEn && vmRun && freq < target && target - freq > step
      |=> freq == $past(freq) + $past(step);
  endproperty
  a_ramp_up : assert property (p_ramp_up)
    else $error("Virtual master did not ramp up by one step.");

  property p_ramp_down;
    sysEn && !vmRun && freq != 16'h0000 && freq > step
      |=> freq == $past(freq) - $past(step);
  endproperty
  a_ramp_down : assert property (p_ramp_down)
    else $error("Virtual master did not ramp down by one step.");

  property p_stay_zero;
    sysEn && !vmRun && freq <= step |=> freq == 16'h0000;
  endproperty
  a_stay_zero : assert property (p_stay_zero)
    else $error("Virtual master left zero while switched off.");
endmodule : cjh_vm_ramp

// >>> rtl/cjh_cmd_core.sv
// Jog, trim, homing, master-select and error-clear command sequencer.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cjh_consts.svh"

module cjh_cmd_core (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 sysEn,
  input  wire logic [4:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output      logic [31:0]          regRdata,
  input  wire logic [1:0]           fastIn,
  input  wire logic [3:0]           ctrlIn,
  input  wire logic [5:0]           serCmd,
  input  wire logic [5:0]           busCmd,
  input  wire logic                 autoCutCmd,
  input  wire logic                 cutIndex,
  input  wire logic                 atHome,
  input  wire logic [7:0]           errIn,
  output      cjh_pkg::cjh_vel_t    rollVel,
  output      logic                 holdPos,
  output      cjh_pkg::cjh_vel_t    trimRate,
  output      logic                 pieceLonger,
  output      logic                 pieceShorter,
  output      logic                 homingBusy,
  output      logic                 homingDone,
  output      logic                 masterVirtual,
  output      cjh_pkg::cjh_speed_t  vmFreq,
  output      logic [7:0]           errLatch,
  output      logic                 errAny
);
  import cjh_pkg::*;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [17:0] srcMap;
  cjh_speed_t  jogSpd;
  cjh_speed_t  trimSpd;
  cjh_speed_t  vmSpd;
  cjh_speed_t  rampStep;

  wire wrMap  = regWr && regAddr == `CJH_OFS_MAP;
  wire wrJog  = regWr && regAddr == `CJH_OFS_JOG;
  wire wrTrim = regWr && regAddr == `CJH_OFS_TRIM;
  wire wrVm   = regWr && regAddr == `CJH_OFS_VMSPD;
  wire wrRamp = regWr && regAddr == `CJH_OFS_RAMP;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      srcMap   <= `CJH_MAP_RST;
      jogSpd   <= `CJH_JOG_RST;
      trimSpd  <= `CJH_TRIM_RST;
      vmSpd    <= `CJH_VMSPD_RST;
      rampStep <= `CJH_RAMP_RST;
    end else if (sysEn) begin
      if (wrMap) srcMap <= regWdata[17:0];
      if (wrJog) jogSpd <= regWdata[15:0];
      if (wrTrim) trimSpd <= regWdata[15:0];
      if (wrVm) vmSpd <= regWdata[15:0];
      if (wrRamp) rampStep <= regWdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Command sources
  // ----------------------------------------------------------------------
  // Source codes: 0 none, 1..2 fast inputs 3..4, 3..6 control 1..4.
  // Code 7 selects the constant zero so a bad code never acts.
  wire [7:0] hwPool = {1'b0, ctrlIn, fastIn, 1'b0};
  wire [5:0] hwCmd;
  wire [5:0] cmd;

  genvar gi;
  generate
    for (gi = 0; gi < `CJH_NCMD; gi = gi + 1) begin : g_cmd
      wire [2:0] code = srcMap[3*gi+2:3*gi];
      assign hwCmd[gi] = hwPool[code];
      assign cmd[gi] = hwCmd[gi] | serCmd[gi] | busCmd[gi];
    end
  endgenerate

  wire jogF = cmd[`CJH_C_JOGF];
  wire jogR = cmd[`CJH_C_JOGR];
  wire vSel = cmd[`CJH_C_VSEL];
  wire vRun = cmd[`CJH_C_VRUN];

  // Edge detection for the commands that act only when switched on.
  logic homePrev;
  logic clrPrev;
  wire  homeRise = cmd[`CJH_C_HOME] && !homePrev;
  wire  clrRise  = cmd[`CJH_C_CLR] && !clrPrev;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      homePrev <= 1'b0;
      clrPrev  <= 1'b0;
    end else if (sysEn) begin
      homePrev <= cmd[`CJH_C_HOME];
      clrPrev  <= cmd[`CJH_C_CLR];
    end
  end

  // ----------------------------------------------------------------------
  // Homing sequence
  // ----------------------------------------------------------------------
  cjh_home_t homeSt;
  cjh_home_t next_homeSt;

  // Homing only starts at standstill; during cutting the roll follows
  // the profile and a search move would spoil the running cut.
  always_comb begin
    next_homeSt = homeSt;
    unique case (homeSt)
      HOME_IDLE: begin
        if (homeRise && !autoCutCmd) next_homeSt = HOME_SEEK;
      end
      HOME_SEEK: begin
        if (cutIndex) next_homeSt = HOME_MOVE;
      end
      HOME_MOVE: begin
        if (atHome) next_homeSt = HOME_IDLE;
      end
      default: next_homeSt = HOME_IDLE;
    endcase
  end

  wire homeIdle   = homeSt == HOME_IDLE;
  wire homeFinish = homeSt == HOME_MOVE && atHome;
  // Motion follows the state being entered, so the roll starts and
  // stops in step with homingBusy.
  wire homeNextIdle = next_homeSt == HOME_IDLE;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      homeSt     <= HOME_IDLE;
      homingDone <= 1'b0;
    end else if (sysEn) begin
      homeSt <= next_homeSt;
      if (homeFinish) homingDone <= 1'b1;
      else if (next_homeSt == HOME_SEEK) homingDone <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Jog and trim decode
  // ----------------------------------------------------------------------
  wire     oneDir  = jogF ^ jogR;
  wire     stopped = !autoCutCmd;
  wire     jogMove = stopped && homeIdle && oneDir;
  wire     trimOn  = autoCutCmd && oneDir;
  cjh_vel_t jogPos;
  cjh_vel_t trimPos;
  assign jogPos  = cjh_vel_t'({1'b0, jogSpd});
  assign trimPos = cjh_vel_t'({1'b0, trimSpd});

  cjh_vel_t next_rollVel;
  cjh_vel_t next_trimRate;
  assign next_rollVel =
    !homeNextIdle ? jogPos :
    !jogMove  ? cjh_vel_t'(17'h00000) :
    jogF      ? jogPos : -jogPos;
  assign next_trimRate =
    !trimOn ? cjh_vel_t'(17'h00000) :
    jogF    ? trimPos : -trimPos;

  wire next_holdPos = stopped && homeNextIdle && !oneDir;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rollVel      <= '0;
      trimRate     <= '0;
      holdPos      <= 1'b1;
      pieceShorter <= 1'b0;
      pieceLonger  <= 1'b0;
      homingBusy   <= 1'b0;
    end else if (sysEn) begin
      rollVel      <= next_rollVel;
      trimRate     <= next_trimRate;
      holdPos      <= next_holdPos;
      // Advancing the knife cuts early, so forward trim shortens.
      pieceShorter <= trimOn && jogF;
      pieceLonger  <= trimOn && jogR;
      homingBusy   <= next_homeSt != HOME_IDLE;
    end
  end

  // ----------------------------------------------------------------------
  // Master selection and virtual master
  // ----------------------------------------------------------------------
  // The selection is frozen during cutting so the master cannot jump
  // under a running cut profile.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      masterVirtual <= 1'b0;
    end else if (sysEn && stopped) begin
      masterVirtual <= vSel;
    end
  end

  cjh_vm_ramp u_ramp (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .sysEn    (sysEn),
    .vmRun    (vRun),
    .target   (vmSpd),
    .rampStep (rampStep),
    .freq     (vmFreq)
  );

  // ----------------------------------------------------------------------
  // Error latch
  // ----------------------------------------------------------------------
  // A new error in the clearing cycle survives the clear.
  wire [7:0] next_errLatch = (clrRise ? 8'h00 : errLatch) | errIn;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      errLatch <= 8'h00;
      errAny   <= 1'b0;
    end else if (sysEn) begin
      errLatch <= next_errLatch;
      errAny   <= |next_errLatch;
    end
  end

  // ----------------------------------------------------------------------
  // Register read back
  // ----------------------------------------------------------------------
  wire [31:0] statWord = {20'h00000, homeSt, homingDone, masterVirtual,
                          errAny, autoCutCmd, cmd};
  wire [31:0] readMux =
    regAddr == `CJH_OFS_MAP   ? {14'h0000, srcMap} :
    regAddr == `CJH_OFS_JOG   ? {16'h0000, jogSpd} :
    regAddr == `CJH_OFS_TRIM  ? {16'h0000, trimSpd} :
    regAddr == `CJH_OFS_VMSPD ? {16'h0000, vmSpd} :
    regAddr == `CJH_OFS_RAMP  ? {16'h0000, rampStep} :
    regAddr == `CJH_OFS_STAT  ? statWord :
    regAddr == `CJH_OFS_VMFRQ ? {16'h0000, vmFreq} :
    regAddr == `CJH_OFS_ERR   ? {24'h000000, errLatch} :
    32'h00000000;

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
    end else if (sysEn) begin
      regRdata <= regRd ? readMux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_jog_fwd;
    sysEn && stopped && homeIdle && jogF && !jogR
      |=> rollVel == {1'b0, $past(jogSpd)};
  endproperty
  a_jog_fwd : assert property (p_jog_fwd)
    else $error("Forward jog not at jog speed.");

  property p_jog_hold;
    sysEn && stopped && homeNextIdle && !jogF && !jogR
      |=> holdPos && rollVel == 17'h00000;
  endproperty
  a_jog_hold : assert property (p_jog_hold)
    else $error("Roll not held after jog release.");

  property p_trim_rev;
    sysEn && autoCutCmd && jogR && !jogF
      |=> trimRate == -$signed({1'b0, $past(trimSpd)}) && rollVel == 0;
  endproperty
  a_trim_rev : assert property (p_trim_rev)
    else $error("Reverse trim not at trim speed.");

  property p_trim_len;
    sysEn && !(jogF ^ jogR) |=> !pieceLonger && !pieceShorter;
  endproperty
  a_trim_len : assert property (p_trim_len)
    else $error("Length change persists without trim.");

  sequence s_home_req;
    sysEn && homeRise && homeIdle && !autoCutCmd;
  endsequence
  sequence s_home_seek;
    homingBusy && rollVel == {1'b0, jogSpd};
  endsequence
  property p_home_start;
    s_home_req |=> s_home_seek;
  endproperty
  a_home_start : assert property (p_home_start)
    else $error("Homing did not start forward search.");

  sequence s_index_found;
    sysEn && homeSt == HOME_SEEK && cutIndex;
  endsequence
  property p_home_index;
    s_index_found |=> homeSt == HOME_MOVE && homingBusy;
  endproperty
  a_home_index : assert property (p_home_index)
    else $error("Homing did not proceed after index pulse.");

  property p_home_level;
    sysEn && homePrev && homeIdle |=> homeSt == HOME_IDLE;
  endproperty
  a_home_level : assert property (p_home_level)
    else $error("Held homing command restarted a cycle.");

  property p_msel_frozen;
    sysEn && autoCutCmd |=> $stable(masterVirtual);
  endproperty
  a_msel_frozen : assert property (p_msel_frozen)
    else $error("Master selection changed during cutting.");

  property p_err_clear;
    sysEn && clrRise && errIn == 8'h00 |=> errLatch == 8'h00 && !errAny;
  endproperty
  a_err_clear : assert property (p_err_clear)
    else $error("Error clear left errors latched.");

  property p_both_dirs;
    sysEn && homeNextIdle && jogF && jogR
      |=> rollVel == 17'h00000 && trimRate == 17'h00000;
  endproperty
  a_both_dirs : assert property (p_both_dirs)
    else $error("Both directions caused motion.");

  property p_or_sources;
    sysEn && (serCmd[`CJH_C_VSEL] || busCmd[`CJH_C_VSEL]) && stopped
      |=> masterVirtual;
  endproperty
  a_or_sources : assert property (p_or_sources)
    else $error("Serial or fieldbus command ignored.");
endmodule : cjh_cmd_core

// >>> tb/cjh_roll_model.sv
// Behavioural roll, index sensor and home detector beside the command block.
`timescale 1ns/1ps

module cjh_roll_model #(
  parameter int PERIOD = 40,
  parameter int IDX_AT = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire cjh_pkg::cjh_vel_t rollVel,
  output      logic              cutIndex,
  output      logic              atHome
);
  import cjh_pkg::*;

  int pos;

  // The roll starts at home, so homing that stops on atHome alone, without
  // first waiting for the index pulse, ends far too early and is caught.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) pos <= 0;
    else if (rollVel > 0) pos <= (pos + 1) % PERIOD;
    else if (rollVel < 0) pos <= (pos + PERIOD - 1) % PERIOD;
  end

  assign cutIndex = (pos == IDX_AT) && (rollVel > 0);
  assign atHome   = (pos == 0);
endmodule : cjh_roll_model

// >>> tb/cjh_cmd_core_tb.sv
// Self-checking bench for the cutter command block.
`timescale 1ns/1ps
`include "cjh_consts.svh"

module cjh_cmd_core_tb;
  import cjh_pkg::*;

  typedef struct {
    logic [5:0] hw, ser, bus;
    logic       cut;
    cjh_vel_t   vel, trim;
    logic       hold, lng, sht;
  } cjh_row_t;

  localparam cjh_vel_t JV = {1'b0, `CJH_JOG_RST};
  localparam cjh_vel_t TV = {1'b0, `CJH_TRIM_RST};

  logic        sys_clk = 0, sys_rst = 1, sysEn = 1;
  logic [4:0]  regAddr = 0;
  logic [31:0] regWdata = 0, regRdata, rdat;
  logic        regWr = 0, regRd = 0, autoCutCmd = 0, seenIdx;
  logic [1:0]  fastIn = 0;
  logic [3:0]  ctrlIn = 0;
  logic [5:0]  serCmd = 0, busCmd = 0;
  logic [7:0]  errIn = 0, errLatch;
  logic        cutIndex, atHome, holdPos, pieceLonger, pieceShorter;
  logic        homingBusy, homingDone, masterVirtual, errAny;
  cjh_vel_t    rollVel, trimRate;
  cjh_speed_t  vmFreq;
  int          fail_count = 0, checks = 0, n, k;

  cjh_row_t rows[8] = '{
    '{6'h00, 6'h00, 6'h00, 1'b0, 0, 0, 1'b1, 1'b0, 1'b0},
    '{6'h08, 6'h00, 6'h00, 1'b0, JV, 0, 1'b0, 1'b0, 1'b0},
    '{6'h00, 6'h02, 6'h00, 1'b0, -JV, 0, 1'b0, 1'b0, 1'b0},
    '{6'h00, 6'h00, 6'h03, 1'b0, 0, 0, 1'b1, 1'b0, 1'b0},
    '{6'h00, 6'h00, 6'h01, 1'b1, 0, TV, 1'b0, 1'b0, 1'b1},
    '{6'h10, 6'h00, 6'h00, 1'b1, 0, -TV, 1'b0, 1'b1, 1'b0},
    '{6'h08, 6'h02, 6'h00, 1'b1, 0, 0, 1'b0, 1'b0, 1'b0},
    '{6'h00, 6'h00, 6'h00, 1'b0, 0, 0, 1'b1, 1'b0, 1'b0}};

  always #5 sys_clk = ~sys_clk;

  cjh_cmd_core dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sysEn(sysEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .fastIn(fastIn),
    .ctrlIn(ctrlIn), .serCmd(serCmd), .busCmd(busCmd),
    .autoCutCmd(autoCutCmd), .cutIndex(cutIndex), .atHome(atHome),
    .errIn(errIn), .rollVel(rollVel), .holdPos(holdPos),
    .trimRate(trimRate), .pieceLonger(pieceLonger),
    .pieceShorter(pieceShorter), .homingBusy(homingBusy),
    .homingDone(homingDone), .masterVirtual(masterVirtual),
    .vmFreq(vmFreq), .errLatch(errLatch), .errAny(errAny)
  );

  cjh_roll_model roll (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .rollVel(rollVel),
    .cutIndex(cutIndex), .atHome(atHome)
  );

  // ----------------------------------------------------------------------
  // Bus, stimulus and comparison tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic step(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic setIn(input logic [5:0] hw, ser, bus, input logic cut);
    @(posedge sys_clk);
    {ctrlIn, fastIn} <= hw;
    serCmd           <= ser;
    busCmd           <= bus;
    autoCutCmd       <= cut;
  endtask : setIn

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1;
    chk("regRdata", e, regRdata);
  endtask : rdChk

  task automatic pulseErr(input logic [7:0] e);
    @(posedge sys_clk);
    errIn <= e;
    @(posedge sys_clk);
    errIn <= 8'h00;
    step(2);
  endtask : pulseErr

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // About 250 cycles are needed; over a hundred times that means a hang.
  initial begin
    #300000;
    fail_count++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(1);
    chk("holdPos", 1, holdPos);
    chk("vmFreq", 0, vmFreq);
    $display("test reset outputs done");
    for (k = 0; k < 8; k++) begin
      setIn(rows[k].hw, rows[k].ser, rows[k].bus, rows[k].cut);
      step(2);
      chk("rollVel", rows[k].vel, rollVel);
      chk("trimRate", rows[k].trim, trimRate);
      chk("pieceLonger", rows[k].lng, pieceLonger);
      chk("pieceShorter", rows[k].sht, pieceShorter);
      if (!rows[k].cut) chk("holdPos", rows[k].hold, holdPos);
    end
    $display("test table done");
    rdChk(`CJH_OFS_MAP, `CJH_MAP_RST);
    rdChk(`CJH_OFS_JOG, `CJH_JOG_RST);
    rdChk(`CJH_OFS_TRIM, `CJH_TRIM_RST);
    rdChk(`CJH_OFS_VMSPD, `CJH_VMSPD_RST);
    rdChk(`CJH_OFS_RAMP, `CJH_RAMP_RST);
    rdChk(5'h01, 32'h0);
    $display("test register reset done");
    // Each source code routes exactly one hardware input; 0 and 7 none.
    wr(`CJH_OFS_JOG, 32'h0123);
    for (k = 0; k < 8; k++) begin
      wr(`CJH_OFS_MAP, k);
      setIn((k == 0 || k == 7) ? 6'h3F : 6'h01 << (k - 1), 0, 0, 0);
      step(2);
      chk("rollVel", (k == 0 || k == 7) ? 0 : 32'h0123, rollVel);
      setIn(0, 0, 0, 0);
    end
    wr(`CJH_OFS_MAP, `CJH_MAP_RST);
    wr(`CJH_OFS_JOG, `CJH_JOG_RST);
    $display("test source map done");
    setIn(0, 6'h04, 0, 0);
    step(2);
    chk("homingBusy", 1, homingBusy);
    chk("rollVel", JV, rollVel);
    seenIdx = 0;
    n = 0;
    while (homingBusy === 1'b1 && n < 200) begin
      step(1);
      if (cutIndex === 1'b1) seenIdx = 1;
      n++;
    end
    chk("indexBeforeHome", 1, seenIdx);
    chk("homingDone", 1, homingDone);
    chk("rollVel", 0, rollVel);
    chk("holdPos", 1, holdPos);
    rdChk(`CJH_OFS_STAT, 32'h0204);
    step(10);
    chk("homingBusy", 0, homingBusy);
    setIn(0, 0, 0, 1);
    setIn(0, 6'h04, 0, 1);
    step(3);
    chk("homingBusy", 0, homingBusy);
    $display("test homing done");
    wr(`CJH_OFS_VMSPD, 32'h0400);
    wr(`CJH_OFS_RAMP, 32'h0100);
    setIn(0, 0, 6'h08, 0);
    step(2);
    chk("masterVirtual", 1, masterVirtual);
    setIn(0, 0, 6'h08, 1);
    setIn(0, 0, 6'h10, 1);
    step(2);
    chk("masterVirtual", 1, masterVirtual);
    n = 0;
    while (vmFreq === 16'h0 && n < 50) begin
      step(1);
      n++;
    end
    for (k = 1; k <= 5; k++) begin
      chk("vmFreq", (k > 2 ? 4 : k + 1) * 32'h100, vmFreq);
      step(1);
    end
    rdChk(`CJH_OFS_VMFRQ, 32'h0400);
    setIn(0, 0, 0, 1);
    n = 0;
    while (vmFreq === 16'h0400 && n < 50) begin
      step(1);
      n++;
    end
    for (k = 3; k >= -1; k--) begin
      chk("vmFreq", (k < 0 ? 0 : k) * 32'h100, vmFreq);
      step(1);
    end
    setIn(0, 0, 0, 0);
    step(2);
    chk("masterVirtual", 0, masterVirtual);
    $display("test virtual master done");
    pulseErr(8'h05);
    chk("errLatch", 8'h05, errLatch);
    chk("errAny", 1, errAny);
    rdChk(`CJH_OFS_ERR, 32'h05);
    setIn(0, 6'h20, 0, 0);
    step(2);
    chk("errLatch", 0, errLatch);
    chk("errAny", 0, errAny);
    pulseErr(8'h80);
    chk("errLatch", 8'h80, errLatch);
    setIn(0, 0, 0, 0);
    setIn(0, 6'h20, 0, 0);
    step(2);
    chk("errLatch", 0, errLatch);
    $display("test error clear done");
    setIn(6'h08, 0, 0, 0);
    pulseErr(8'h01);
    // With the enable low, neither a new direction nor a new error acts.
    @(posedge sys_clk);
    sysEn  <= 1'b0;
    serCmd <= 6'h02;
    errIn  <= 8'h02;
    step(3);
    chk("rollVel", JV, rollVel);
    chk("errLatch", 8'h01, errLatch);
    @(posedge sys_clk);
    sysEn  <= 1'b1;
    serCmd <= 6'h00;
    errIn  <= 8'h00;
    $display("test clock enable done");
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk("rollVel", 0, rollVel);
    chk("holdPos", 1, holdPos);
    chk("errLatch", 0, errLatch);
    setIn(0, 0, 0, 0);
    $display("test mid-run reset done");
    test_done;
  end
endmodule : cjh_cmd_core_tb
